/* rtl/pin_conditioner.sv */
`timescale 1ns/1ps
`default_nettype none
`include "reset_supervisor_watchdog_defs.svh"

module pin_conditioner #(
	parameter logic [7:0] FILTER_CYCLES = 8'(`NOISE_CYCLES),
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// raw pin and filtered level
	input wire logic pinIn,
	output logic pinOut
);

	reset_supervisor_pkg::cond_state_t c_reg, c_next;

	// ----------------------------------------
	// synchroniser and glitch filter
	// ----------------------------------------
	always_comb
	begin
		c_next = c_reg;
		c_next.sync = {c_reg.sync[1:0], pinIn};
		// stages 2 and 3 must agree; only they are compared
		if (c_reg.sync[2] != c_reg.sync[1] || c_reg.sync[2] == c_reg.level)
			c_next.stable = 8'h00;
		else if (c_reg.stable == FILTER_CYCLES - 8'h01)
		begin
			c_next.level = c_reg.sync[2];
			c_next.stable = 8'h00;
		end
		else
			c_next.stable = c_reg.stable + 8'h01; // short pulses count up here but are cleared before reaching the limit
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			c_reg <= '{sync: {3{RESET_LEVEL}}, stable: 8'h00, level: RESET_LEVEL};
		else
			c_reg <= c_next;
	end

	assign pinOut = c_reg.level;

endmodule : pin_conditioner
`default_nettype wire

/* rtl/reset_supervisor_pkg.sv */
`include "reset_supervisor_watchdog_defs.svh"

package reset_supervisor_pkg;

	// ----------------------------------------
	// supervisor states
	// ----------------------------------------
	typedef enum logic [1:0] {
		HOLD_LOW,
		TIMING,
		RELEASED
	} supv_state_t;

	// gating handed to the serial protocol engine
	typedef struct packed {
		logic busEnable;
		logic dataAckEnable;
		logic programBusy;
	} access_gate_t;

	// open-drain reset pin pair, output values and enables
	typedef struct packed {
		logic highOut;
		logic highOe;
		logic lowOut;
		logic lowOe;
	} reset_pins_t;

	// conditioner state
	typedef struct packed {
		logic [2:0] sync;
		logic [7:0] stable;
		logic level;
	} cond_state_t;

	// supervisor state
	typedef struct packed {
		supv_state_t st;
		logic [4:0] div;
		logic [`TIMER_WIDTH-1:0] timer;
		logic [`TIMER_WIDTH-1:0] wdog;
		logic [`TIMER_WIDTH-1:0] busyCnt;
		logic [4:0] settle;
		logic prevHigh;
		logic prevLow;
		logic prevSda;
		reset_pins_t pins;
		access_gate_t gate;
	} supv_reg_t;

endpackage : reset_supervisor_pkg

/* rtl/reset_supervisor_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
`include "reset_supervisor_watchdog_defs.svh"

module reset_supervisor_watchdog #(
	parameter logic [`TIMER_WIDTH-1:0] POWER_UP_TICKS = `TIMER_WIDTH'(`POWER_UP_TICKS),
	parameter logic [`TIMER_WIDTH-1:0] WATCHDOG_TICKS = `TIMER_WIDTH'(`WATCHDOG_TICKS),
	parameter logic [`TIMER_WIDTH-1:0] WRITE_TICKS = `TIMER_WIDTH'(`WRITE_CYCLE_TICKS),
	parameter logic WATCHDOG_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// supply comparator and pins
	input wire logic supplyOkIn,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic writeProtectIn,
	input wire logic resetHighIn,
	input wire logic resetLowIn,
	// reset pin drive
	output var reset_supervisor_pkg::reset_pins_t resetPins,
	// protocol engine side
	input wire logic writeStop,
	output logic sclClean,
	output logic sdaClean,
	output var reset_supervisor_pkg::access_gate_t gate
);

	// ----------------------------------------
	// counter helpers
	// ----------------------------------------
	// true on the last count of a span of limit ticks
	function automatic logic lastCount(
		input logic [`TIMER_WIDTH-1:0] cnt,
		input logic [`TIMER_WIDTH-1:0] limit
	);
		// a zero limit never matches, so no span collapses to nothing
		lastCount = (limit != '0) && (cnt == limit - `TIMER_WIDTH'(1));
	endfunction : lastCount

	// one step of a tick counter
	function automatic logic [`TIMER_WIDTH-1:0] stepCount(
		input logic [`TIMER_WIDTH-1:0] cnt
	);
		stepCount = cnt + `TIMER_WIDTH'(1);
	endfunction : stepCount

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	localparam int NPIN = 6;
	// idle level of each pin, also the conditioner's reset level
	localparam logic [NPIN-1:0] PIN_IDLE = 6'h1C;
	logic [NPIN-1:0] rawPins;
	logic [NPIN-1:0] cleanPins;
	logic supplyOk, wpHigh, pinHigh, pinLow;

	// supply idles low, buses and low reset idle high, high reset low
	assign rawPins = {supplyOkIn, sclIn, sdaIn, resetLowIn, writeProtectIn,
		resetHighIn};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : gCond
			pin_conditioner #(
				.RESET_LEVEL(PIN_IDLE[gi])
			) uCond (
				.ref_clk(ref_clk),
				.rst(rst),
				.pinIn(rawPins[gi]),
				.pinOut(cleanPins[gi])
			);
		end
	endgenerate

	assign supplyOk = cleanPins[5];
	assign sclClean = cleanPins[4];
	assign sdaClean = cleanPins[3];
	assign pinLow = cleanPins[2];
	assign wpHigh = cleanPins[1]; // floating pin pulled low outside
	assign pinHigh = cleanPins[0];

	// ----------------------------------------
	// supervisor state
	// ----------------------------------------
	reset_supervisor_pkg::supv_reg_t s_reg, s_next;
	logic tick, settled, forcedEdge, forcedLevel, wdogExpire, resetActive;
	logic busyNext;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		// free-running 1 us time base
		tick = (s_reg.div == 5'(`TICK_CYCLES - 1));
		s_next.div = tick ? 5'h00 : s_reg.div + 5'h01;
		s_next.prevHigh = pinHigh;
		s_next.prevLow = pinLow;
		s_next.prevSda = sdaClean;
		settled = (s_reg.settle == 5'(`PIN_SETTLE_CYCLES));
		// pins read back our own drive until the pull resistors win
		if (s_reg.st == reset_supervisor_pkg::RELEASED && !settled)
			s_next.settle = s_reg.settle + 5'h01;
		forcedEdge = settled && ((pinHigh && !s_reg.prevHigh) ||
			(!pinLow && s_reg.prevLow));
		// a level held through our own drive cannot be told from it,
		// so it is seen again only after each release and settle;
		// the outputs drop for about the settle cycles then
		forcedLevel = settled && (pinHigh || !pinLow);
		wdogExpire = WATCHDOG_PRESENT && tick &&
			lastCount(s_reg.wdog, WATCHDOG_TICKS);

		// ----------------------------------------
		// reset sequencing
		// ----------------------------------------
		case (s_reg.st)
			reset_supervisor_pkg::HOLD_LOW:
			begin
				s_next.timer = '0;
				if (supplyOk)
					s_next.st = reset_supervisor_pkg::TIMING;
			end
			reset_supervisor_pkg::TIMING:
			begin
				if (tick)
					s_next.timer = stepCount(s_reg.timer);
				if (tick && lastCount(s_reg.timer, POWER_UP_TICKS))
				begin
					s_next.st = reset_supervisor_pkg::RELEASED;
					s_next.settle = 5'h00;
				end
			end
			reset_supervisor_pkg::RELEASED:
			begin
				if (forcedEdge || forcedLevel || wdogExpire)
				begin
					s_next.st = reset_supervisor_pkg::TIMING;
					s_next.timer = '0;
				end
			end
			default:
				s_next.st = reset_supervisor_pkg::HOLD_LOW;
		endcase
		// supply loss overrides everything, within a few cycles
		if (!supplyOk)
		begin
			s_next.st = reset_supervisor_pkg::HOLD_LOW;
			s_next.timer = '0;
		end

		// ----------------------------------------
		// watchdog on data line activity
		// ----------------------------------------
		if (s_next.st != reset_supervisor_pkg::RELEASED)
			s_next.wdog = '0;
		else if (sdaClean != s_reg.prevSda)
			s_next.wdog = '0;
		else if (tick && WATCHDOG_PRESENT)
			s_next.wdog = stepCount(s_reg.wdog);

		// ----------------------------------------
		// open-drain drive: enable only while asserting
		// ----------------------------------------
		resetActive = (s_next.st != reset_supervisor_pkg::RELEASED);
		s_next.pins.highOe = resetActive;
		s_next.pins.highOut = resetActive;
		s_next.pins.lowOe = resetActive;
		s_next.pins.lowOut = 1'b0;

		// ----------------------------------------
		// programming cycle
		// ----------------------------------------
		// a stop of a protected write programs nothing
		busyNext = s_reg.gate.programBusy;
		if (writeStop && s_reg.gate.dataAckEnable)
		begin
			busyNext = 1'b1;
			s_next.busyCnt = '0;
		end
		else if (s_reg.gate.programBusy && tick)
		begin
			s_next.busyCnt = stepCount(s_reg.busyCnt);
			// rounded down so the cycle never overruns
			if (lastCount(s_reg.busyCnt, WRITE_TICKS))
				busyNext = 1'b0;
		end
		s_next.gate.programBusy = busyNext;
		s_next.gate.busEnable = !resetActive && !busyNext;
		// address still acked when protected, data byte is not
		s_next.gate.dataAckEnable = !resetActive && !busyNext && !wpHigh &&
			supplyOk;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.st <= reset_supervisor_pkg::HOLD_LOW;
			s_reg.prevLow <= 1'b1;
			s_reg.prevSda <= 1'b1;
			s_reg.pins.highOe <= 1'b1; // reset asserted from the start
			s_reg.pins.highOut <= 1'b1;
			s_reg.pins.lowOe <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign resetPins = s_reg.pins;
	assign gate = s_reg.gate;

endmodule : reset_supervisor_watchdog
`default_nettype wire

/* rtl/reset_supervisor_watchdog_defs.svh */
`ifndef RESET_SUPERVISOR_WATCHDOG_DEFS_SVH
`define RESET_SUPERVISOR_WATCHDOG_DEFS_SVH

// ----------------------------------------
// clock and time base
// ----------------------------------------
`define CLK_FREQ_HZ 25000000
`define TICK_PERIOD_NS 1000
// cycles per 1 us time-base tick
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_NS / 1000)

// ----------------------------------------
// supervisory timing
// ----------------------------------------
`define POWER_UP_RESET_TIMEOUT_MS 200
`define POWER_UP_TICKS (`POWER_UP_RESET_TIMEOUT_MS * 1000)
`define WATCHDOG_PERIOD_MS 1600
`define WATCHDOG_TICKS (`WATCHDOG_PERIOD_MS * 1000)
`define WRITE_CYCLE_TIME_MS 10
`define WRITE_CYCLE_TICKS (`WRITE_CYCLE_TIME_MS * 1000)
`define THRESHOLD_TO_RESET_DELAY_US 5

// ----------------------------------------
// input conditioning
// ----------------------------------------
`define NOISE_SUPPRESS_NS 200
// least time, rounded up to whole cycles
`define NOISE_CYCLES ((`NOISE_SUPPRESS_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
// ignore reset pins this long after our own release
`define PIN_SETTLE_CYCLES 16
`define TIMER_WIDTH 24

`endif

/* tb/mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	// clock
	input wire logic ref_clk,
	// drive and requests
	input wire reset_supervisor_pkg::reset_pins_t resetPins,
	input wire logic forceHigh,
	input wire logic forceLow,
	input wire logic alive,
	// wire levels
	output logic resetHighIn,
	output logic resetLowIn,
	output var logic sdaIn
);
	logic [8:0] beat_reg = 9'h0;
	// pulldown on the high wire, pullup on the low wire
	assign resetHighIn = (resetPins.highOe & resetPins.highOut) | forceHigh;
	assign resetLowIn = ~((resetPins.lowOe & ~resetPins.lowOut) | forceLow);
	// keep-alive toggle at half the watchdog span
	initial sdaIn = 1'b1;
	always @(posedge ref_clk)
	begin
		beat_reg <= beat_reg + 9'h1;
		if (alive && beat_reg == 9'h1FF)
			sdaIn <= ~sdaIn;
	end
endmodule : mcu_model
`default_nettype wire

/* tb/reset_supervisor_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor_monitor #(
	parameter int POWER_UP_TICKS = 20,
	parameter int WATCHDOG_TICKS = 40,
	parameter int WRITE_TICKS = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// watched ports
	input wire logic supplyOkIn,
	input wire logic sdaIn,
	input wire logic writeProtectIn,
	input wire logic writeStop,
	input wire reset_supervisor_pkg::reset_pins_t resetPins,
	input wire reset_supervisor_pkg::access_gate_t gate
);
	localparam int PU_LO = POWER_UP_TICKS * 25 - 20;
	localparam int PU_HI = POWER_UP_TICKS * 25 + 60;
	localparam int WR_LO = WRITE_TICKS * 25 - 40;
	localparam int WR_HI = WRITE_TICKS * 25 + 10;
	localparam int WD_MAX = WATCHDOG_TICKS * 25 + 80;
	logic [15:0] idle_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// idle span of the data line; margin covers filter and partial tick
	always_ff @(posedge ref_clk)
		if (rst || resetPins.highOe || $changed(sdaIn))
			idle_reg <= 16'h0;
		else
			idle_reg <= idle_reg + 16'h1;
	sequence s_start;
		writeStop && gate.dataAckEnable;
	endsequence
	sequence s_busy;
		gate.programBusy && !gate.busEnable && !gate.dataAckEnable;
	endsequence
	a_pins_paired: assert property (resetPins.highOe == resetPins.lowOe)
		else $error("reset pins differ");
	a_hold_low: assert property ((!supplyOkIn)[*8] ##1 (!supplyOkIn)[*8] |->
		resetPins.highOe && !gate.dataAckEnable) else $error("low supply");
	a_release_time: assert property ($rose(supplyOkIn) ##1 supplyOkIn[*8] |->
		##[PU_LO:PU_HI] !resetPins.highOe) else $error("release time");
	a_supply_loss: assert property ($fell(supplyOkIn) ##1 (!supplyOkIn)[*4] |->
		##[0:120] resetPins.highOe) else $error("late assert");
	a_wdog_bound: assert property (idle_reg <= WD_MAX)
		else $error("watchdog late");
	a_no_ack_reset: assert property (resetPins.highOe[*2] |-> !gate.busEnable)
		else $error("bus open in reset");
	a_wp_locks: assert property (writeProtectIn[*8] ##1 writeProtectIn[*8] |->
		!gate.dataAckEnable) else $error("protected write");
	a_write_start: assert property (s_start |=> s_busy)
		else $error("write start");
	a_write_end: assert property (s_start ##1 s_busy[*8] |->
		##[WR_LO:WR_HI] !gate.programBusy) else $error("write end");
endmodule : reset_supervisor_monitor
bind reset_supervisor_watchdog reset_supervisor_monitor #(
	.POWER_UP_TICKS(POWER_UP_TICKS), .WATCHDOG_TICKS(WATCHDOG_TICKS),
	.WRITE_TICKS(WRITE_TICKS)) i_reset_supervisor_monitor (
	.ref_clk(ref_clk), .rst(rst), .supplyOkIn(supplyOkIn), .sdaIn(sdaIn),
	.writeProtectIn(writeProtectIn), .writeStop(writeStop),
	.resetPins(resetPins), .gate(gate));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int PU = 20;
	localparam int WD = 40;
	localparam int WR = 10;
	typedef struct packed { logic wp; logic expAck; } row_t;
	row_t rows [3] = '{'{1'b0, 1'b1}, '{1'b1, 1'b0}, '{1'b0, 1'b1}};
	logic ref_clk = 1'b0, rst = 1'b1, supplyOkIn = 1'b0, sclIn = 1'b0;
	logic writeProtectIn = 1'b0, writeStop = 1'b0, forceHigh = 1'b0;
	logic forceLow = 1'b0, alive = 1'b0, sdaIn, resetHighIn, resetLowIn;
	logic sclClean, sdaClean;
	reset_supervisor_pkg::reset_pins_t resetPins;
	reset_supervisor_pkg::access_gate_t gate;
	int errorCnt = 0, nCompared = 0, n;
	reset_supervisor_watchdog #(.POWER_UP_TICKS(24'(PU)),
		.WATCHDOG_TICKS(24'(WD)), .WRITE_TICKS(24'(WR)))
		i_reset_supervisor_watchdog (.ref_clk(ref_clk), .rst(rst),
		.supplyOkIn(supplyOkIn), .sclIn(sclIn), .sdaIn(sdaIn),
		.writeProtectIn(writeProtectIn), .resetHighIn(resetHighIn),
		.resetLowIn(resetLowIn), .resetPins(resetPins), .writeStop(writeStop),
		.sclClean(sclClean), .sdaClean(sdaClean), .gate(gate));
	mcu_model i_mcu_model (.ref_clk(ref_clk), .resetPins(resetPins),
		.forceHigh(forceHigh), .forceLow(forceLow), .alive(alive),
		.resetHighIn(resetHighIn), .resetLowIn(resetLowIn), .sdaIn(sdaIn));
	// free-running clock
	initial forever #20 ref_clk = ~ref_clk;
	task automatic check(input logic seen, input logic exp);
		nCompared++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("wrong value at %0t: %0h not %0h", $time, seen, exp);
		end
	endtask : check
	// bounded wait on the reset drive, leaves the span in n
	task automatic waitOe(input logic val, input int lim);
		n = 0;
		while (resetPins.highOe !== val && n < lim)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(n < lim, 1'b1);
		@(posedge ref_clk);
	endtask : waitOe
	task automatic conclude();
		$display("compared %0d, mismatched %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	// hang guard, well beyond the expected few thousand cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errorCnt++;
		conclude();
	end
	// main sequence
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (20) @(negedge ref_clk);
		check(resetPins.highOe, 1'b1);
		check(resetLowIn, 1'b0);
		check(gate.dataAckEnable, 1'b0);
		@(posedge ref_clk);
		supplyOkIn <= 1'b1;
		alive <= 1'b1;
		waitOe(1'b0, 700);
		check(n >= PU * 25 - 20, 1'b1);
		check(resetHighIn, 1'b0);
		check(resetLowIn, 1'b1);
		$display("power-up test done");
		foreach (rows[i])
		begin
			writeProtectIn <= rows[i].wp;
			repeat (20) @(negedge ref_clk);
			check(gate.dataAckEnable, rows[i].expAck);
			check(gate.busEnable, 1'b1);
			@(posedge ref_clk);
			writeStop <= 1'b1;
			@(posedge ref_clk);
			writeStop <= 1'b0;
			@(negedge ref_clk);
			check(gate.busEnable, !rows[i].expAck);
			repeat (WR * 25 + 20) @(negedge ref_clk);
			check(gate.programBusy, 1'b0);
			@(posedge ref_clk);
		end
		$display("write gating test done");
		sclIn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sclIn <= 1'b0;
		repeat (12) @(negedge ref_clk) check(sclClean, 1'b0);
		@(posedge ref_clk);
		sclIn <= 1'b1;
		repeat (12) @(negedge ref_clk);
		check(sclClean, 1'b1);
		@(posedge ref_clk);
		sclIn <= 1'b0;
		repeat (12) @(negedge ref_clk);
		check(sclClean, 1'b0);
		$display("noise test done");
		@(posedge ref_clk);
		forceHigh <= 1'b1;
		waitOe(1'b1, 30);
		forceHigh <= 1'b0;
		waitOe(1'b0, 700);
		check(n >= PU * 25 - 40, 1'b1);
		forceLow <= 1'b1;
		waitOe(1'b1, 60);
		repeat (PU * 25 + 100) @(negedge ref_clk);
		check(resetPins.highOe, 1'b1);
		check(gate.busEnable, 1'b0);
		@(posedge ref_clk);
		forceLow <= 1'b0;
		waitOe(1'b0, 1200);
		$display("manual reset test done");
		@(sdaIn);
		@(posedge ref_clk);
		alive <= 1'b0;
		repeat (12) @(negedge ref_clk);
		check(sdaClean, sdaIn);
		waitOe(1'b1, 1300);
		check(n >= WD * 25 - 60, 1'b1);
		waitOe(1'b0, 700);
		waitOe(1'b1, 1300);
		check(n >= WD * 25 - 40, 1'b1);
		alive <= 1'b1;
		waitOe(1'b0, 700);
		$display("watchdog test done");
		supplyOkIn <= 1'b0;
		waitOe(1'b1, 125);
		repeat (4) @(negedge ref_clk);
		check(gate.busEnable, 1'b0);
		check(gate.dataAckEnable, 1'b0);
		$display("supply loss test done");
		conclude();
	end
endmodule : tb
`default_nettype wire
